// ===== rtl/core_timer_pkg.sv
`default_nettype none
package core_timer_pkg;
    // ======================================================================
    // register map
    localparam logic [12:0] STATUS_CONTROL_ADDR = 13'h0008;
    localparam logic [12:0] COUNT_VALUE_ADDR    = 13'h0009;
    localparam logic [12:0] MISC_CONTROL_ADDR   = 13'h000b;
    localparam logic [12:0] WATCHDOG_CLEAR_ADDR = 13'h1ff0;
    // ======================================================================
    // status/control fields
    localparam int OVF_FLAG_BIT   = 7;
    localparam int TICK_FLAG_BIT  = 6;
    localparam int OVF_IE_BIT     = 5;
    localparam int TICK_IE_BIT    = 4;
    localparam int OVF_RST_BIT    = 3;
    localparam int TICK_RST_BIT   = 2;
    localparam int RATE_HI_BIT    = 1;
    localparam int RATE_LO_BIT    = 0;
    localparam int WD_ENABLE_BIT  = 0;
    localparam int WD_RESTART_BIT = 0;
    localparam logic [1:0] RATE_RESET = 2'h3;
    // ======================================================================
    // counter chain geometry
    localparam int PRESCALE_BITS  = 2;
    localparam int CHAIN_BITS     = 15;
    localparam int VIEW_BITS      = 8;
    localparam int TICK_BASE_EXP  = 14;
    localparam int WD_BITS        = 4;
    localparam int TICK_SRC_BASE  = TICK_BASE_EXP - 1;
    localparam int WD_PULSE_CYC   = 4;
    localparam int STARTUP_CYC    = 4064;
    localparam int POR_SHORT_CYC  = 16;
    // ======================================================================
    typedef struct packed {
        logic [12:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;
    typedef enum logic [1:0] {
        ST_RUN    = 2'h0,
        ST_STOP   = 2'h1,
        ST_SETTLE = 2'h2
    } mode_e;
endpackage : core_timer_pkg
`default_nettype wire

// ===== rtl/core_timer_rti_watchdog.sv
`default_nettype none
module core_timer_rti_watchdog (
    input  wire logic                   mclk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   por_i,
    input  wire logic                   por_short_i,
    input  wire logic [12:0]            addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [7:0]             rdata_o,
    input  wire logic                   hv_detect_i,
    input  wire logic                   wait_mode_i,
    input  wire logic                   stop_req_i,
    input  wire logic                   stop_exit_i,
    output logic                        irq_o,
    output logic                        wake_o,
    output logic                        reset_pin_low_o,
    output logic                        reset_pin_oe_o,
    output logic                        por_busy_o
);
    // ======================================================================
    // input synchronisers for pin level signals
    logic [1:0] hv_sync_r;
    logic [1:0] exit_sync_r;
    logic       hv_det;
    logic       stop_exit;
    always_ff @(posedge mclk_i) begin
        hv_sync_r <= {hv_sync_r[0], hv_detect_i};
    end

    always_ff @(posedge mclk_i) begin
        exit_sync_r <= {exit_sync_r[0], stop_exit_i};
    end
    assign hv_det    = hv_sync_r[1];
    assign stop_exit = exit_sync_r[1];

    // ======================================================================
    // bus request carrier
    core_timer_pkg::bus_req_s req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ======================================================================
    // register decode
    wire sc_sel  = (req.addr == core_timer_pkg::STATUS_CONTROL_ADDR);
    wire cnt_sel = (req.addr == core_timer_pkg::COUNT_VALUE_ADDR);
    wire mc_sel  = (req.addr == core_timer_pkg::MISC_CONTROL_ADDR);
    wire wdc_sel = (req.addr == core_timer_pkg::WATCHDOG_CLEAR_ADDR);

    wire sc_wr  = req.wr && sc_sel;
    wire mc_wr  = req.wr && mc_sel;
    wire wdc_wr = req.wr && wdc_sel;

    // ======================================================================
    // mode control: run, stop, settle
    core_timer_pkg::mode_e mode_r;
    core_timer_pkg::mode_e mode_nxt;
    logic [11:0] settle_r;
    logic [11:0] settle_nxt;
    logic        por_done_r;
    logic        por_clear;

    localparam logic [11:0] SETTLE_LAST = 12'(core_timer_pkg::STARTUP_CYC - 1);
    localparam logic [11:0] SHORT_LAST  = 12'(core_timer_pkg::POR_SHORT_CYC - 1);
    wire [11:0] settle_end = (por_short_i && !por_done_r) ? SHORT_LAST : SETTLE_LAST;
    wire        settle_hit = (settle_r == settle_end);

    always_comb begin
        mode_nxt   = mode_r;
        settle_nxt = 12'h000;
        case (mode_r)
            core_timer_pkg::ST_RUN: begin
                if (stop_req_i) begin
                    mode_nxt = core_timer_pkg::ST_STOP;
                end
            end
            core_timer_pkg::ST_STOP: begin
                if (stop_exit || sys_rst_i) begin
                    mode_nxt = core_timer_pkg::ST_SETTLE;
                end
            end
            core_timer_pkg::ST_SETTLE: begin
                settle_nxt = settle_r + 12'h001;
                if (settle_hit) begin
                    mode_nxt   = core_timer_pkg::ST_RUN;
                    settle_nxt = 12'h000;
                end
            end
            default: begin
                mode_nxt = core_timer_pkg::ST_RUN;
            end
        endcase
    end

    // ======================================================================
    // power on and stop settle timer
    // power on delay
    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            mode_r     <= core_timer_pkg::ST_SETTLE;
            settle_r   <= 12'h000;
            por_done_r <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            settle_r <= settle_nxt;
            if (mode_r == core_timer_pkg::ST_SETTLE && settle_hit) begin
                por_done_r <= 1'b1;
            end
        end
    end

    // ======================================================================
    // counter chain: prescaler plus fifteen stages
    localparam int TOTAL = core_timer_pkg::PRESCALE_BITS + core_timer_pkg::CHAIN_BITS;
    logic [TOTAL-1:0] chain_r;
    wire settle_done = (mode_r == core_timer_pkg::ST_SETTLE) && settle_hit;
    wire chain_clr   = (mode_r == core_timer_pkg::ST_STOP) || settle_done;
    assign por_clear = por_i;
    wire stop_settle = (mode_r == core_timer_pkg::ST_SETTLE) && por_done_r;
    wire chain_run   = (mode_r != core_timer_pkg::ST_STOP) && !stop_settle;
    wire [TOTAL-1:0] chain_inc = chain_r + {{(TOTAL-1){1'b0}}, 1'b1};
    logic [TOTAL-1:0] chain_nxt;
    assign chain_nxt = (por_clear || chain_clr) ? '0 :
                       chain_run                ? chain_inc :
                       chain_r;

    always_ff @(posedge mclk_i) begin
        chain_r <= chain_nxt;
    end

    // ======================================================================
    // overflow detect and count view
    wire [7:0] view = chain_r[core_timer_pkg::PRESCALE_BITS +: core_timer_pkg::VIEW_BITS];
    localparam logic [TOTAL-1:0] OVF_MASK = {{(TOTAL - 10){1'b0}}, 10'h3ff};
    wire ovf_evt = chain_run && ((chain_r & OVF_MASK) == OVF_MASK);

    // ======================================================================
    // tick divider taps, one per rate code
    logic [3:0] tap_evt;
    logic [1:0] rate_r;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_tap
            localparam int N = core_timer_pkg::TICK_BASE_EXP + gi;
            localparam logic [N-1:0] FULL = '1;
            if (N <= TOTAL) begin : g_in
                assign tap_evt[gi] = chain_run && (chain_r[N-1:0] == FULL);
            end else begin : g_ext
                assign tap_evt[gi] = 1'b0;
            end
        end
    endgenerate

    // ======================================================================
    // tick select
    // selected tap drives watchdog
    wire tick_evt = tap_evt[rate_r];

    // ======================================================================
    // status/control register
    logic       ovf_flag_r;
    logic       ovf_flag_nxt;
    logic       tick_flag_r;
    logic       tick_flag_nxt;
    logic       ovf_ie_r;
    logic       ovf_ie_nxt;
    logic       tick_ie_r;
    logic       tick_ie_nxt;
    logic [1:0] rate_nxt;
    wire        rst_any  = sys_rst_i || por_i;
    wire        ovf_clr  = sc_wr && req.wdata[core_timer_pkg::OVF_RST_BIT];
    wire        tick_clr = sc_wr && req.wdata[core_timer_pkg::TICK_RST_BIT];

    // ======================================================================
    // flag next values
    // set beats clear
    assign ovf_flag_nxt  = ovf_evt ? 1'b1 : (ovf_clr ? 1'b0 : ovf_flag_r);
    assign tick_flag_nxt = tick_evt ? 1'b1 : (tick_clr ? 1'b0 : tick_flag_r);
    assign ovf_ie_nxt    = sc_wr ? req.wdata[core_timer_pkg::OVF_IE_BIT] : ovf_ie_r;
    assign tick_ie_nxt   = sc_wr ? req.wdata[core_timer_pkg::TICK_IE_BIT] : tick_ie_r;
    assign rate_nxt      = sc_wr ? {req.wdata[core_timer_pkg::RATE_HI_BIT],
                                    req.wdata[core_timer_pkg::RATE_LO_BIT]} : rate_r;

    // ======================================================================
    // flag and enable flops
    always_ff @(posedge mclk_i) begin
        if (rst_any) begin
            ovf_flag_r  <= 1'b0;
            tick_flag_r <= 1'b0;
        end else begin
            ovf_flag_r  <= ovf_flag_nxt;
            tick_flag_r <= tick_flag_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_any) begin
            ovf_ie_r  <= 1'b0;
            tick_ie_r <= 1'b0;
            rate_r    <= core_timer_pkg::RATE_RESET;
        end else begin
            ovf_ie_r  <= ovf_ie_nxt;
            tick_ie_r <= tick_ie_nxt;
            rate_r    <= rate_nxt;
        end
    end

    // ======================================================================
    // watchdog
    logic                               wd_en_r;
    logic                               wd_en_nxt;
    logic                               wd_once_r;
    logic                               wd_once_nxt;
    logic [core_timer_pkg::WD_BITS-1:0] wd_cnt_r;
    logic [core_timer_pkg::WD_BITS-1:0] wd_cnt_nxt;
    logic [2:0]                         pulse_r;
    logic [2:0]                         pulse_nxt;
    wire wd_active  = wd_en_r && !hv_det;
    wire wd_restart = wdc_wr && !req.wdata[core_timer_pkg::WD_RESTART_BIT];
    wire wd_cnt_max = (wd_cnt_r == '1);
    wire wd_expire  = wd_active && tick_evt && wd_cnt_max;
    wire wd_lock    = mc_wr && !wd_once_r;

    // ======================================================================
    // watchdog enable, write once
    // single write
    assign wd_once_nxt = wd_lock ? 1'b1 : wd_once_r;
    assign wd_en_nxt   = wd_lock ? req.wdata[core_timer_pkg::WD_ENABLE_BIT] : wd_en_r;

    always_ff @(posedge mclk_i) begin
        if (rst_any) begin
            wd_en_r   <= 1'b0;
            wd_once_r <= 1'b0;
        end else begin
            wd_en_r   <= wd_en_nxt;
            wd_once_r <= wd_once_nxt;
        end
    end

    // ======================================================================
    // watchdog stages
    // tick clocks watchdog
    assign wd_cnt_nxt = (wd_restart || !wd_active) ? '0 :
                        tick_evt                   ? wd_cnt_r + 4'h1 :
                        wd_cnt_r;
    always_ff @(posedge mclk_i) begin
        if (rst_any) begin
            wd_cnt_r <= '0;
        end else begin
            wd_cnt_r <= wd_cnt_nxt;
        end
    end

    // ======================================================================
    // reset pulse stretcher
    // pulse four cycles
    localparam logic [2:0] PULSE_LEN = 3'(core_timer_pkg::WD_PULSE_CYC);
    assign pulse_nxt = wd_expire         ? PULSE_LEN :
                       (pulse_r != 3'h0) ? pulse_r - 3'h1 :
                       pulse_r;
    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            pulse_r <= 3'h0;
        end else begin
            pulse_r <= pulse_nxt;
        end
    end

    // ======================================================================
    // read data select
    // reset bits read zero
    wire [7:0] sc_view = {ovf_flag_r, tick_flag_r, ovf_ie_r, tick_ie_r, 2'b00, rate_r};
    wire [7:0] mc_view = {7'h00, wd_en_r};
    wire [7:0] rd_mux =
        sc_sel  ? sc_view :
        cnt_sel ? view :
        mc_sel  ? mc_view :
        8'h00;
    wire [7:0] rdata_nxt = req.rd ? rd_mux : 8'h00;

    // ======================================================================
    // interrupt and wake requests
    // overflow request
    wire ovf_req  = ovf_flag_r && ovf_ie_r;
    wire tick_req = tick_flag_r && tick_ie_r;
    wire irq_nxt  = ovf_req || tick_req;
    wire wake_nxt = wait_mode_i && irq_nxt;

    // ======================================================================
    // reset pin drive
    // pin pulldown
    wire pin_oe_nxt = wd_expire || (pulse_r > 3'h1);
    wire busy_nxt   = !por_done_r;

    // ======================================================================
    // registered outputs
    always_ff @(posedge mclk_i) begin
        if (rst_any) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_any) begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o  <= irq_nxt;
            wake_o <= wake_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            reset_pin_low_o <= 1'b0;
            reset_pin_oe_o  <= 1'b0;
            por_busy_o      <= 1'b1;
        end else begin
            reset_pin_low_o <= 1'b0;
            reset_pin_oe_o  <= pin_oe_nxt;
            por_busy_o      <= busy_nxt;
        end
    end
endmodule : core_timer_rti_watchdog
`default_nettype wire

// ===== testbench/core_timer_rti_watchdog_properties.sv
`default_nettype none
module core_timer_rti_watchdog_checker (
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic        por_i,
    input wire logic [12:0] addr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        hv_detect_i,
    input wire logic        wait_mode_i,
    input wire logic        irq_o,
    input wire logic        wake_o,
    input wire logic        reset_pin_low_o,
    input wire logic        reset_pin_oe_o
);
    // ======================================================================
    // properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i || por_i);
    property p_rdata_idle;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read slot");
    property p_clear_reads_zero;
        $past(rd_i) && $past(addr_i) == core_timer_pkg::WATCHDOG_CLEAR_ADDR |-> rdata_o == 8'h00;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero)
        else $error("watchdog clear register read not zero");
    property p_reset_bits_zero;
        $past(rd_i) && $past(addr_i) == core_timer_pkg::STATUS_CONTROL_ADDR |-> rdata_o[3:2] == 2'h0;
    endproperty
    a_reset_bits_zero: assert property (p_reset_bits_zero)
        else $error("flag reset bits read back nonzero");
    property p_irq_status;
        $past(rd_i) && $past(addr_i) == core_timer_pkg::STATUS_CONTROL_ADDR
            |-> irq_o == ((rdata_o[7] & rdata_o[5]) | (rdata_o[6] & rdata_o[4]));
    endproperty
    a_irq_status: assert property (p_irq_status)
        else $error("irq output disagrees with flags and enables");
    property p_oe_pulse;
        $rose(reset_pin_oe_o) |-> reset_pin_oe_o [*4] ##1 !reset_pin_oe_o;
    endproperty
    a_oe_pulse: assert property (p_oe_pulse)
        else $error("reset pin pulse not four cycles");
    property p_pin_low;
        reset_pin_oe_o |-> !reset_pin_low_o;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("reset pin driven high");
    property p_hv_block;
        $past(hv_detect_i, 1) && $past(hv_detect_i, 2) && $past(hv_detect_i, 3)
            |-> !$rose(reset_pin_oe_o);
    endproperty
    a_hv_block: assert property (p_hv_block)
        else $error("watchdog fired during high voltage");
    property p_wake;
        wake_o |-> irq_o && $past(wait_mode_i);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without irq in wait");
endmodule : core_timer_rti_watchdog_checker
bind core_timer_rti_watchdog core_timer_rti_watchdog_checker core_timer_rti_watchdog_checker_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .por_i(por_i), .addr_i(addr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .hv_detect_i(hv_detect_i), .wait_mode_i(wait_mode_i), .irq_o(irq_o),
    .wake_o(wake_o), .reset_pin_low_o(reset_pin_low_o), .reset_pin_oe_o(reset_pin_oe_o));
`default_nettype wire

// ===== testbench/core_timer_rti_watchdog_tb_top.sv
`default_nettype none
module core_timer_rti_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ======================================================================
    // signals
    logic mclk_i = 0, sys_rst_i = 1, por_i = 1, por_short_i = 1, wr_i = 0, rd_i = 0;
    logic hv_detect_i = 0, wait_mode_i = 0, stop_req_i = 0, stop_exit_i = 0;
    logic [12:0] addr_i = 13'h0000;
    logic [7:0]  wdata_i = 8'h00, rdata_o, v, w;
    logic irq_o, wake_o, reset_pin_low_o, reset_pin_oe_o, por_busy_o;
    int fails = 0, n_checks = 0;
    localparam logic [12:0] ST = core_timer_pkg::STATUS_CONTROL_ADDR;
    localparam logic [12:0] CNT = core_timer_pkg::COUNT_VALUE_ADDR;
    always #20 mclk_i = ~mclk_i;
    core_timer_rti_watchdog core_timer_rti_watchdog_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .por_i(por_i), .por_short_i(por_short_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hv_detect_i(hv_detect_i),
        .wait_mode_i(wait_mode_i), .stop_req_i(stop_req_i), .stop_exit_i(stop_exit_i),
        .irq_o(irq_o), .wake_o(wake_o), .reset_pin_low_o(reset_pin_low_o),
        .reset_pin_oe_o(reset_pin_oe_o), .por_busy_o(por_busy_o));
    // ======================================================================
    // bus tasks
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask : chk
    task automatic reg_wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [12:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : reg_rd
    task automatic wait_status(input int b, input int lim);
        v = 8'h00;
        for (int i = 0; i < lim && v[b] !== 1'b1; i++) reg_rd(ST, v);
        chk("status flag", 8'h01, {7'h00, v[b]});
    endtask : wait_status
    task automatic test_done;
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // ======================================================================
    // tests
    initial begin
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        por_i <= 1'b0;
        for (int i = 0; i < 100 && por_busy_o !== 1'b0; i++) @(posedge mclk_i);
        chk("por busy", 8'h00, {7'h00, por_busy_o});
        reg_rd(ST, v); chk("status reset", 8'h03, v);
        reg_rd(13'h0100, v); chk("unmapped", 8'h00, v);
        reg_rd(CNT, v);
        repeat (2) @(posedge mclk_i);
        reg_rd(CNT, w); chk("count step", v + 8'h01, w);
        wait_status(7, 600);
        reg_wr(ST, 8'h23);
        reg_rd(ST, v); chk("ovf enable", 8'ha3, v & 8'hbf);
        chk("ovf irq", 8'h01, {7'h00, irq_o});
        reg_wr(ST, 8'h23);
        reg_rd(ST, v); chk("flag write ignored", 8'h80, v & 8'h80);
        reg_wr(ST, 8'h0b);
        reg_rd(ST, v); chk("ovf cleared", 8'h03, v);
        repeat (2) @(posedge mclk_i);
        chk("irq off", 8'h00, {7'h00, irq_o});
        reg_wr(core_timer_pkg::WATCHDOG_CLEAR_ADDR, 8'h00);
        reg_wr(ST, 8'h10);
        wait_status(6, 9000);
        wait_mode_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk("tick irq", 8'h01, {7'h00, irq_o});
        chk("wake", 8'h01, {7'h00, wake_o});
        reg_wr(ST, 8'h04);
        wait_mode_i <= 1'b0;
        reg_rd(ST, v); chk("tick cleared", 8'h00, v & 8'h7f);
        reg_wr(core_timer_pkg::WATCHDOG_CLEAR_ADDR, 8'h00);
        reg_rd(core_timer_pkg::WATCHDOG_CLEAR_ADDR, v); chk("clear reads", 8'h00, v);
        hv_detect_i <= 1'b1;
        reg_wr(core_timer_pkg::MISC_CONTROL_ADDR, 8'h01);
        reg_wr(core_timer_pkg::MISC_CONTROL_ADDR, 8'h00);
        reg_rd(core_timer_pkg::MISC_CONTROL_ADDR, v); chk("wd enable once", 8'h01, v);
        reg_wr(CNT, 8'hff);
        chk("no pulse", 8'h00, {7'h00, reset_pin_oe_o});
        reg_wr(ST, 8'h30);
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        reg_rd(ST, v); chk("sys reset", 8'h03, v & 8'h3f);
        reg_rd(core_timer_pkg::MISC_CONTROL_ADDR, v); chk("wd off", 8'h00, v);
        @(posedge mclk_i);
        stop_req_i <= 1'b1;
        @(posedge mclk_i);
        stop_req_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        reg_rd(CNT, v); chk("stop count", 8'h00, v);
        stop_exit_i <= 1'b1;
        repeat (2000) @(posedge mclk_i);
        reg_rd(CNT, v); chk("settle count", 8'h00, v);
        repeat (2300) @(posedge mclk_i);
        stop_exit_i <= 1'b0;
        reg_rd(CNT, v); chk("resumed", 8'h01, {7'h00, v != 8'h00});
        hv_detect_i <= 1'b0;
        por_short_i <= 1'b0;
        por_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        por_i <= 1'b0;
        repeat (2000) @(posedge mclk_i);
        chk("long startup busy", 8'h01, {7'h00, por_busy_o});
        for (int i = 0; i < 3000 && por_busy_o !== 1'b0; i++) @(posedge mclk_i);
        chk("long startup done", 8'h00, {7'h00, por_busy_o});
        reg_rd(CNT, v); chk("recleared count", 8'h01, {7'h00, v < 8'h08});
        test_done();
    end
    initial begin
        repeat (100000) @(posedge mclk_i);
        fails++;
        test_done();
    end
endmodule : core_timer_rti_watchdog_tb_top
`default_nettype wire
